// File: logic/fault_flag_pwm_reporter.sv
// Fault flag registers with APB access and PWM error reporting.
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module fault_flag_pwm_reporter
  import fault_pwm_pkg::*;
#(
  parameter int STEP_CYC = PERIOD_STEP_CYC,
  parameter int MIN_BASE = DUTY_MIN_BASE,
  parameter int MAX_BASE = DUTY_MAX_BASE,
  parameter int LIMIT_STEP = DUTY_LIMIT_STEP
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] err_cond,
  input wire logic encoder_integrity_err,
  input wire logic encoder_slew_warn,
  input wire logic encoder_countup_done,
  input wire logic turns_warn_p,
  input wire logic turns_overflow_p,
  input wire logic turns_warn_s,
  input wire logic turns_overflow_s,
  input wire logic [15:0] angle_pos,
  output logic pwm_o,
  output logic pwm_oe,
  output logic irq
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] err_pri;
    logic [15:0] err_red;
    logic [15:0] arm_pri;
    logic [15:0] arm_red;
    logic [4:0] stat;
    logic [1:0] turns_p;
    logic [1:0] turns_s;
    logic fault_tristate_en;
    logic [3:0] per_sel;
    logic [2:0] duty_limit_sel;
    logic [3:0] irq_stat;
    logic [3:0] irq_en;
    logic [3:0] ev_prev;
    mode_t mode;
    logic [1:0] hiz_left;
    logic pwm;
    logic pwm_oe;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } st_t;

  st_t q;
  st_t d;

  // Bus decode helpers.
  logic setup;
  logic access_done;
  logic [5:0] idx;
  logic mapped;
  logic [31:0] rd_word;

  // Error ranking.
  logic [10:0] ranked;
  logic [3:0] rank;
  logic any_ranked;
  logic top_fault;
  logic any_err;

  // Duty and carrier settings.
  logic [13:0] err_duty;
  logic [13:0] min_duty;
  logic [13:0] max_duty;
  logic [13:0] span;
  logic [29:0] scaled;
  logic [13:0] norm_duty;
  logic [17:0] base_per;
  logic [17:0] core_per;
  logic [13:0] core_duty;

  // Carrier feedback and interrupt events.
  logic wrap;
  logic level;
  logic [3:0] ev_now;
  logic [15:0] clearable;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------

  // Error duty lookup for the winning rank.
  duty_rom u_rom (
    .pclk(pclk),
    .presetn(presetn),
    .rank(rank),
    .sel(q.duty_limit_sel),
    .duty_q(err_duty)
  );

  // Carrier generator.
  pwm_core u_core (
    .pclk(pclk),
    .presetn(presetn),
    .period(core_per),
    .duty(core_duty),
    .wrap(wrap),
    .level_q(level)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------

  // The slave answers in the first access cycle after setup.
  assign setup = psel && !penable && !q.pready;
  assign access_done = psel && penable && q.pready;
  assign idx = paddr[7:2];

  // Bad addresses answer with an error and change nothing.
  // Read mux and address map.
  always_comb begin
    rd_word = '0;
    mapped = (paddr[1:0] == 2'h0);
    case (idx)
      REG_STATUS: rd_word[4:0] = q.stat;
      REG_ERR_PRI: rd_word[15:0] = q.err_pri;
      REG_ERR_RED: rd_word[15:0] = q.err_red;
      REG_TURNS_P, REG_TURNS_LP: begin
        rd_word[TURNS_WARN_BIT] = q.turns_p[1];
        rd_word[TURNS_OVF_BIT] = q.turns_p[0];
      end
      REG_TURNS_S, REG_TURNS_LS: begin
        rd_word[TURNS_WARN_BIT] = q.turns_s[1];
        rd_word[TURNS_OVF_BIT] = q.turns_s[0];
      end
      REG_CFG_TRI: rd_word[TRI_EN_BIT] = q.fault_tristate_en;
      REG_CFG_PERIOD: rd_word[PER_SEL_LSB +: 4] = q.per_sel;
      REG_CFG_PORCH: rd_word[PORCH_LSB +: 3] = q.duty_limit_sel;
      REG_IRQ_STAT: rd_word[3:0] = q.irq_stat;
      REG_IRQ_CLR: rd_word = '0;
      REG_IRQ_EN: rd_word[3:0] = q.irq_en;
      default: mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Error priority
  // ----------------------------------------------------------------

  // These four flags clear only on reset, so the pin floats until then.
  // Top group bypasses the ranking and always floats the pin.
  assign top_fault = q.err_pri[ERR_OSC] | q.err_pri[ERR_SHADOW] |
    q.err_pri[ERR_NVM_MULTI] | q.err_pri[ERR_NVM_SINGLE];

  // Rank 0 is the highest priority below the top group.
  assign ranked = {
    q.stat[STAT_COUNTUP_BIT],
    q.stat[STAT_INTEGRITY_BIT] | q.stat[STAT_SLEW_BIT],
    q.err_pri[ERR_MISMATCH],
    q.err_pri[ERR_FLD_LOW],
    q.err_pri[ERR_CLIP],
    q.err_pri[ERR_FLD_HIGH],
    q.err_pri[ERR_TEMP],
    q.err_pri[ERR_OVER_V],
    q.err_pri[ERR_VCHK],
    q.err_pri[ERR_UNDER_V],
    q.err_pri[ERR_POR]
  };

  // Lowest set index wins, so only the highest priority error reports.
  always_comb begin
    rank = 4'hF;
    for (int i = 10; i >= 0; i--) begin
      if (ranked[i]) begin
        rank = 4'(i);
      end
    end
  end

  // Any ranked or top group flag counts as an error.
  assign any_ranked = |ranked;
  assign any_err = any_ranked | top_fault;

  // ----------------------------------------------------------------
  // Duty and period selection
  // ----------------------------------------------------------------

  // Duty limits narrow as the select rises; angle maps between them.
  assign min_duty = 14'(MIN_BASE + int'(q.duty_limit_sel) * LIMIT_STEP);
  assign max_duty = 14'(MAX_BASE - int'(q.duty_limit_sel) * LIMIT_STEP);

  // The angle fraction scales the span above the lower limit.
  assign span = max_duty - min_duty;
  assign scaled = 30'(span) * 30'(angle_pos);
  assign norm_duty = min_duty + scaled[29:16];

  // Carrier period in clock cycles for the chosen step count.
  assign base_per = 18'(STEP_CYC * (int'(q.per_sel) + 1));

  // The core loads settings at the wrap, along with the mode change.
  // Error duty mode doubles the period count, halving the carrier.
  always_comb begin
    if (d.mode == MODE_ERR_DUTY) begin
      core_per = {base_per[16:0], 1'b0};
      core_duty = err_duty;
    end else begin
      core_per = base_per;
      core_duty = norm_duty;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Sticky flags never clear by a read; events feed the interrupts.
  assign clearable = ~STICKY_MASK;
  assign ev_now = {
    q.stat[STAT_INTEGRITY_BIT] | q.stat[STAT_SLEW_BIT],
    |{q.turns_p, q.turns_s},
    top_fault,
    |q.err_pri
  };

  // Next value of every state bit.
  always_comb begin
    d = q;
    // Bus handshake and registered read data.
    d.pready = setup;
    d.pslverr = setup && !mapped;
    if (setup) begin
      d.prdata = rd_word;
    end

    // Error flags: set wins; read arms the clear of held flags.
    // A flag whose condition still stands survives the read.
    if (access_done && !pwrite && idx == REG_ERR_PRI && mapped) begin
      d.arm_pri = q.arm_pri | q.err_pri;
    end
    if (access_done && !pwrite && idx == REG_ERR_RED && mapped) begin
      d.arm_red = q.arm_red | q.err_red;
    end
    d.err_pri = err_cond | (q.err_pri & ~(d.arm_pri & ~err_cond & clearable));
    d.err_red = err_cond | (q.err_red & ~(d.arm_red & ~err_cond & clearable));
    d.arm_pri = d.arm_pri & d.err_pri;
    d.arm_red = d.arm_red & d.err_red;

    // Live status and sticky turns flags.
    d.stat = {encoder_slew_warn, encoder_integrity_err, encoder_countup_done,
      2'b00};
    d.turns_p = q.turns_p | {turns_warn_p, turns_overflow_p};
    d.turns_s = q.turns_s | {turns_warn_s, turns_overflow_s};

    // Configuration writes.
    if (access_done && pwrite && mapped) begin
      case (idx)
        REG_CFG_TRI: d.fault_tristate_en = pwdata[TRI_EN_BIT];
        REG_CFG_PERIOD: d.per_sel = pwdata[PER_SEL_LSB +: 4];
        REG_CFG_PORCH: d.duty_limit_sel = pwdata[PORCH_LSB +: 3];
        REG_IRQ_EN: d.irq_en = pwdata[3:0];
        default: d.irq_en = q.irq_en;
      endcase
    end

    // Interrupt status: a rising event sets, write-one clears, set wins.
    d.ev_prev = ev_now;
    if (access_done && pwrite && mapped && idx == REG_IRQ_CLR) begin
      d.irq_stat = q.irq_stat & ~pwdata[3:0];
    end
    d.irq_stat = d.irq_stat | (ev_now & ~q.ev_prev);
    d.irq = |(d.irq_stat & d.irq_en);

    // Output mode changes only at the carrier wrap.
    // This keeps every period whole on the pin.
    if (wrap) begin
      case (q.mode)
        MODE_NORMAL: begin
          if (top_fault || (any_err && q.fault_tristate_en)) begin
            d.mode = MODE_HIZ;
            d.hiz_left = 2'(HIZ_MIN_PERIODS);
          end else if (any_ranked) begin
            d.mode = MODE_ERR_DUTY;
          end
        end
        MODE_ERR_DUTY: begin
          if (top_fault || (any_err && q.fault_tristate_en)) begin
            d.mode = MODE_HIZ;
            d.hiz_left = 2'(HIZ_MIN_PERIODS);
          end else if (!any_ranked) begin
            d.mode = MODE_NORMAL;
          end
        end
        MODE_HIZ: begin
          if (q.hiz_left != 2'h0) begin
            d.hiz_left = q.hiz_left - 2'h1;
          end else if (top_fault || (any_err && q.fault_tristate_en)) begin
            d.mode = MODE_HIZ;
          end else if (any_ranked) begin
            d.mode = MODE_ERR_DUTY;
          end else begin
            d.mode = MODE_NORMAL;
          end
        end
        default: d.mode = MODE_NORMAL;
      endcase
    end

    // Pin drive: floating in the high impedance mode.
    d.pwm_oe = (d.mode != MODE_HIZ);
    d.pwm = level & (d.mode != MODE_HIZ);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------

  // Power-on flag starts set in both error registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.err_pri <= ERR_RESET_VAL;
      q.err_red <= ERR_RESET_VAL;
      q.per_sel <= PER_SEL_RESET;
      q.duty_limit_sel <= PORCH_RESET;
      q.mode <= MODE_NORMAL;
      q.pwm_oe <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register.
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign pwm_o = q.pwm;
  assign pwm_oe = q.pwm_oe;
  assign irq = q.irq;
endmodule

// File: logic/fault_pwm_pkg.sv
// Shared constants and types for the fault flag PWM reporter.
// What this block does
// - Error bits 0-4 in both error registers.
// - Field low bit 5, field high bit 6.
// - Undervolt bit 7, overvolt 8, power-on 9.
// - NVM single 10, multi 11, shadow 12.
// - Busy 13, execute error 14, interface 15.
// - Encoder integrity bit 3, slew bit 4 status.
// - Turns warn bit 13, overflow bit 12.
// - Tristate enable: errors float pin at least three periods.
// - Tristate off: half frequency, error duty.
// - Several errors: highest priority duty only.
// - Top group always floats pin, full duty.
// - Duty limit select sets limits and error duty.
// - Fixed ranking of errors below top group.
// - Tabulated duty per error and setting.
// - Top group flags clear only on reset.
// - Flags hold until read and condition gone.
package fault_pwm_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int PERIOD_STEP_NS = 10000;
  localparam int PERIOD_STEP_CYC = PERIOD_STEP_NS / CLK_PERIOD_NS;
  localparam int HIZ_MIN_PERIODS = 2;
  localparam int DUTY_FULL = 10000;
  localparam int DUTY_MIN_BASE = 500;
  localparam int DUTY_MAX_BASE = 9500;
  localparam int DUTY_LIMIT_STEP = 100;
  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] REG_STATUS = 6'h0E;
  localparam logic [5:0] REG_ERR_PRI = 6'h11;
  localparam logic [5:0] REG_ERR_RED = 6'h12;
  localparam logic [5:0] REG_TURNS_P = 6'h15;
  localparam logic [5:0] REG_TURNS_LP = 6'h1B;
  localparam logic [5:0] REG_TURNS_S = 6'h1C;
  localparam logic [5:0] REG_TURNS_LS = 6'h1D;
  localparam logic [5:0] REG_CFG_TRI = 6'h24;
  localparam logic [5:0] REG_CFG_PERIOD = 6'h25;
  localparam logic [5:0] REG_CFG_PORCH = 6'h2A;
  localparam logic [5:0] REG_IRQ_STAT = 6'h30;
  localparam logic [5:0] REG_IRQ_CLR = 6'h31;
  localparam logic [5:0] REG_IRQ_EN = 6'h32;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TRI_EN_BIT = 20;
  localparam int PER_SEL_LSB = 19;
  localparam int PORCH_LSB = 23;
  localparam int TURNS_WARN_BIT = 13;
  localparam int TURNS_OVF_BIT = 12;
  localparam int STAT_COUNTUP_BIT = 2;
  localparam int STAT_INTEGRITY_BIT = 3;
  localparam int STAT_SLEW_BIT = 4;
  localparam int ERR_VCHK = 0;
  localparam int ERR_TEMP = 1;
  localparam int ERR_CLIP = 2;
  localparam int ERR_OSC = 3;
  localparam int ERR_MISMATCH = 4;
  localparam int ERR_FLD_LOW = 5;
  localparam int ERR_FLD_HIGH = 6;
  localparam int ERR_UNDER_V = 7;
  localparam int ERR_OVER_V = 8;
  localparam int ERR_POR = 9;
  localparam int ERR_NVM_SINGLE = 10;
  localparam int ERR_NVM_MULTI = 11;
  localparam int ERR_SHADOW = 12;
  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [15:0] ERR_RESET_VAL = 16'h0200;
  localparam logic [15:0] STICKY_MASK = 16'h1C08;
  localparam logic [3:0] PER_SEL_RESET = 4'h0;
  localparam logic [2:0] PORCH_RESET = 3'h0;
  // Interrupt event positions.
  localparam int IRQ_ERR_SET = 0;
  localparam int IRQ_TOP_FAULT = 1;
  localparam int IRQ_TURNS = 2;
  localparam int IRQ_ENCODER = 3;
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b001,
    MODE_ERR_DUTY = 3'b010,
    MODE_HIZ = 3'b100
  } mode_t;
endpackage

// File: logic/duty_rom.sv
// Error duty table, indexed by priority rank and duty limit select.
`timescale 1ns/1ps
module duty_rom
  import fault_pwm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] rank,
  input wire logic [2:0] sel,
  output logic [13:0] duty_q
);
  typedef struct packed {
    logic [13:0] duty;
  } rom_st_t;
  rom_st_t q;
  rom_st_t d;
  logic [111:0] row;
  // Rows list settings 0 to 7 from left, in hundredths of a percent.
  always_comb begin
    case (rank)
      4'h0: row = {14'd1631, 14'd1627, 14'd1627, 14'd1629, 14'd1635, 14'd1644, 14'd1624, 14'd1631};
      4'h1: row = {14'd3889, 14'd3876, 14'd3864, 14'd3888, 14'd3878, 14'd3870, 14'd3864, 14'd3889};
      4'h2: row = {14'd3325, 14'd3323, 14'd3322, 14'd3324, 14'd3326, 14'd3297, 14'd3304, 14'd3325};
      4'h3: row = {14'd7240, 14'd7267, 14'd7255, 14'd7241, 14'd7260, 14'd7243, 14'd7256, 14'd7240};
      4'h4: row = {14'd6675, 14'd6677, 14'd6678, 14'd6676, 14'd6674, 14'd6703, 14'd6696, 14'd6675};
      4'h5: row = {14'd6111, 14'd6124, 14'd6136, 14'd6112, 14'd6122, 14'd6130, 14'd6136, 14'd6111};
      4'h6: row = {14'd5659, 14'd5645, 14'd5667, 14'd5653, 14'd5673, 14'd5658, 14'd5675, 14'd5659};
      4'h7: row = {14'd4454, 14'd4429, 14'd4441, 14'd4453, 14'd4431, 14'd4444, 14'd4424, 14'd4454};
      4'h8: row = {14'd2195, 14'd2180, 14'd2204, 14'd2194, 14'd2187, 14'd2184, 14'd2184, 14'd2195};
      4'h9: row = {14'd2760, 14'd2733, 14'd2745, 14'd2759, 14'd2740, 14'd2757, 14'd2744, 14'd2760};
      4'hA: row = {14'd8407, 14'd8410, 14'd8409, 14'd8406, 14'd8399, 14'd8389, 14'd8409, 14'd8407};
      default: row = {8{14'd10000}};
    endcase
    d.duty = row[14 * (7 - int'(sel)) +: 14];
  end
  // Registered read port.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign duty_q = q.duty;
endmodule

// File: logic/pwm_core.sv
// Carrier counter and duty comparator, reloading period and duty each cycle end.
`timescale 1ns/1ps
module pwm_core
  import fault_pwm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [17:0] period,
  input wire logic [13:0] duty,
  output logic wrap,
  output logic level_q
);
  typedef struct packed {
    logic [17:0] cnt;
    logic [17:0] per;
    logic [13:0] duty;
    logic level;
  } core_st_t;
  core_st_t q;
  core_st_t d;
  localparam logic [31:0] FULL = 32'(DUTY_FULL);
  // A zero period after reset wraps at once, so the first settings load.
  assign wrap = (q.per == 18'h00000) || (q.cnt >= q.per - 18'h00001);
  // Count through the period, then take new settings at the wrap.
  always_comb begin
    d = q;
    if (wrap) begin
      d.cnt = '0;
      d.per = period;
      d.duty = duty;
    end else begin
      d.cnt = q.cnt + 18'h00001;
    end
    d.level = (32'(d.cnt) * FULL) < (32'(d.duty) * 32'(d.per));
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign level_q = q.level;
endmodule

// File: test/fault_pwm_props.sv
// Checker for the fault flag PWM reporter ports.
`timescale 1ns/1ps
module fault_pwm_props
  import fault_pwm_pkg::*;
#(
  parameter int STEP_CYC = PERIOD_STEP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] err_cond,
  input wire logic pwm_o,
  input wire logic pwm_oe
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  localparam int HIZ_WAIT = 800;
  int hiz_q;
  logic rd_pri;
  logic rd_red;
  logic [15:0] held;
  logic [15:0] cond_q;
  // Counts floating cycles and keeps conditions seen at two edges.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hiz_q <= 0;
      cond_q <= 16'h0000;
      held <= 16'h0000;
    end else begin
      hiz_q <= pwm_oe ? 0 : hiz_q + 1;
      cond_q <= err_cond;
      held <= err_cond & cond_q;
    end
  end
  // Completed reads of the two error registers.
  assign rd_pri = psel && penable && pready && !pwrite && paddr == {REG_ERR_PRI, 2'b00};
  assign rd_red = psel && penable && pready && !pwrite && paddr == {REG_ERR_RED, 2'b00};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_ready_follows: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_bad_addr: assert property (psel && !penable && paddr[1:0] != 2'b00 |=> pready && pslverr)
    else $error("misaligned access not refused");
  a_float_quiet: assert property (!pwm_oe |-> !pwm_o)
    else $error("level driven while floating");
  a_osc_float: assert property ($rose(err_cond[ERR_OSC]) |-> ##[1:HIZ_WAIT] !pwm_oe)
    else $error("oscillator fault did not float pin");
  a_nvm_float: assert property ($rose(err_cond[ERR_NVM_MULTI]) |-> ##[1:HIZ_WAIT] !pwm_oe)
    else $error("memory fault did not float pin");
  a_hiz_span: assert property ($rose(pwm_oe) |-> hiz_q >= 2 * STEP_CYC)
    else $error("float shorter than two periods");
  a_pri_sets: assert property (rd_pri |-> (prdata[15:0] & held) == held)
    else $error("primary flag missing");
  a_red_sets: assert property (rd_red |-> (prdata[15:0] & held) == held)
    else $error("redundant flag missing");
endmodule
bind fault_flag_pwm_reporter fault_pwm_props #(.STEP_CYC(STEP_CYC)) u_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .err_cond(err_cond), .pwm_o(pwm_o),
  .pwm_oe(pwm_oe));

// File: test/pwm_host.sv
// Host model that times the PWM line it decodes.
`timescale 1ns/1ps
module pwm_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pwm_o,
  input wire logic pwm_oe,
  output int hi_cnt,
  output int per_cnt,
  output int n_per
);
  int hi;
  int cyc;
  logic prev;
  logic line;
  // The pull-up holds the line high while the pin floats.
  assign line = pwm_oe ? pwm_o : 1'b1;
  // Measures high span and period between rising edges of the line.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi <= 0;
      cyc <= 0;
      prev <= 1'b1;
      n_per <= 0;
    end else begin
      prev <= line;
      if (line && !prev) begin
        per_cnt <= cyc;
        hi_cnt <= hi;
        n_per <= n_per + 1;
        cyc <= 1;
        hi <= 1;
      end else begin
        cyc <= cyc + 1;
        hi <= hi + int'(line);
      end
    end
  end
endmodule

// File: test/fault_flag_pwm_reporter_tb.sv
// Self-checking bench for the fault flag PWM reporter.
`timescale 1ns/1ps
module fault_flag_pwm_reporter_tb;
  import fault_pwm_pkg::*;
  typedef struct {logic [15:0] cond; logic [2:0] enc; logic [15:0] ang; int per; int duty;} row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] addr_lo = 2'b00;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] err_cond = 16'h0;
  logic [2:0] enc = 3'h0;
  logic [3:0] turns = 4'h0;
  logic [15:0] angle = 16'h0;
  logic pwm_o;
  logic pwm_oe;
  logic irq;
  logic [31:0] rd;
  logic serr;
  int hi_cnt;
  int per_cnt;
  int n_per;
  int error_cnt = 0;
  int compares = 0;
  int tops[4] = '{ERR_OSC, ERR_NVM_SINGLE, ERR_NVM_MULTI, ERR_SHADOW};
  // Ordinary cases at period select 0 and duty limit select 0.
  row_t rows[17] = '{'{16'h0000, 3'h0, 16'h0000, 100, 500}, '{16'h0000, 3'h0, 16'h8000, 100, 5000},
    '{16'h0001, 3'h0, 16'h0, 200, 3325}, '{16'h0002, 3'h0, 16'h0, 200, 6675},
    '{16'h0004, 3'h0, 16'h0, 200, 5659}, '{16'h0010, 3'h0, 16'h0, 200, 2195},
    '{16'h0020, 3'h0, 16'h0, 200, 4454}, '{16'h0040, 3'h0, 16'h0, 200, 6111},
    '{16'h0080, 3'h0, 16'h0, 200, 3889}, '{16'h0100, 3'h0, 16'h0, 200, 7240},
    '{16'h0200, 3'h0, 16'h0, 200, 1631}, '{16'hE000, 3'h0, 16'h8000, 100, 5000},
    '{16'h0000, 3'h2, 16'h0, 200, 2760}, '{16'h0000, 3'h4, 16'h0, 200, 2760},
    '{16'h0000, 3'h1, 16'h0, 200, 8407}, '{16'h0181, 3'h0, 16'h0, 200, 3889},
    '{16'h0057, 3'h0, 16'h0, 200, 3325}};
  // Clock of 40 ns.
  always #20 pclk = ~pclk;
  fault_flag_pwm_reporter #(.STEP_CYC(100)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .err_cond(err_cond), .encoder_integrity_err(enc[1]),
    .encoder_slew_warn(enc[2]), .encoder_countup_done(enc[0]), .turns_warn_p(turns[0]),
    .turns_overflow_p(turns[1]), .turns_warn_s(turns[2]), .turns_overflow_s(turns[3]),
    .angle_pos(angle), .pwm_o(pwm_o), .pwm_oe(pwm_oe), .irq(irq));
  pwm_host host (.pclk(pclk), .presetn(presetn), .pwm_o(pwm_o), .pwm_oe(pwm_oe),
    .hi_cnt(hi_cnt), .per_cnt(per_cnt), .n_per(n_per));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // One APB transfer with an idle cycle after it; register index in, byte address out.
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, addr_lo};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_near(input int got, input int exp);
    compares++;
    if (got > exp + 2 || got < exp - 2) begin
      error_cnt++;
      $display("BAD %0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  // Waits for k further line periods seen by the host.
  task automatic settle(input int k);
    int s;
    int t;
    s = n_per;
    t = 0;
    while (n_per < s + k && t < 20000) begin
      @(posedge pclk);
      t++;
    end
  endtask
  task automatic wait_oe(input logic v);
    int t;
    t = 0;
    while (pwm_oe !== v && t < 1000) begin
      @(posedge pclk);
      t++;
    end
    chk({31'h0, pwm_oe}, {31'h0, v});
  endtask
  task automatic do_reset;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  task close_out;
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    repeat (40000) @(posedge pclk);
    error_cnt++;
    close_out();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge pclk);
    chk(prdata, 32'h0);
    chk({30'h0, pwm_oe, irq}, 32'h2);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(0, REG_IRQ_STAT, 32'h0);
    chk(rd, 32'h1);
    apb(1, REG_IRQ_EN, 32'h1);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1, REG_IRQ_EN, 32'h0);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1, REG_IRQ_CLR, 32'h1);
    apb(1, REG_IRQ_EN, 32'h1);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(0, REG_ERR_PRI, 32'h0);
    chk(rd, 32'h0200);
    apb(0, REG_ERR_RED, 32'h0);
    chk(rd, 32'h0200);
    apb(1, REG_ERR_PRI, 32'hFFFF);
    apb(0, REG_ERR_PRI, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, serr}, 32'h0);
    apb(0, 6'h01, 32'h0);
    chk({31'h0, serr}, 32'h1);
    addr_lo = 2'b01;
    apb(0, REG_ERR_PRI, 32'h0);
    chk({31'h0, serr}, 32'h1);
    addr_lo = 2'b00;
    foreach (rows[i]) begin
      err_cond <= rows[i].cond;
      enc <= rows[i].enc;
      angle <= rows[i].ang;
      settle(3);
      chk_near(per_cnt, rows[i].per);
      chk_near(hi_cnt, rows[i].per * rows[i].duty / 10000);
      apb(0, REG_ERR_PRI, 32'h0);
      chk(rd, {16'h0, rows[i].cond});
      apb(0, REG_ERR_RED, 32'h0);
      chk(rd, {16'h0, rows[i].cond});
      apb(0, REG_STATUS, 32'h0);
      chk(rd & 32'h1C, {27'h0, rows[i].enc, 2'b00});
      err_cond <= 16'h0;
      enc <= 3'h0;
      repeat (2) @(posedge pclk);
    end
    apb(1, REG_CFG_PERIOD, 32'h0008_0000);
    apb(1, REG_CFG_PORCH, 32'h0100_0000);
    settle(3);
    chk_near(hi_cnt, 200 * 700 / 10000);
    err_cond <= 16'h0080;
    settle(3);
    chk_near(per_cnt, 400);
    chk_near(hi_cnt, 400 * 3864 / 10000);
    apb(1, REG_CFG_PERIOD, 32'h0);
    apb(1, REG_CFG_PORCH, 32'h0);
    apb(1, REG_CFG_TRI, 32'h0010_0000);
    err_cond <= 16'h0002;
    wait_oe(1'b0);
    err_cond <= 16'h0;
    apb(0, REG_ERR_PRI, 32'h0);
    wait_oe(1'b1);
    apb(1, REG_CFG_TRI, 32'h0);
    turns <= 4'h9;
    repeat (2) @(posedge pclk);
    turns <= 4'h0;
    repeat (2) @(posedge pclk);
    apb(0, REG_TURNS_P, 32'h0);
    chk(rd & 32'h3000, 32'h2000);
    apb(0, REG_TURNS_LP, 32'h0);
    chk(rd & 32'h3000, 32'h2000);
    apb(0, REG_TURNS_S, 32'h0);
    chk(rd & 32'h3000, 32'h1000);
    apb(0, REG_TURNS_LS, 32'h0);
    chk(rd & 32'h3000, 32'h1000);
    foreach (tops[i]) begin
      do_reset();
      err_cond[tops[i]] <= 1'b1;
      repeat (2) @(posedge pclk);
      err_cond <= 16'h0;
      wait_oe(1'b0);
      apb(0, REG_ERR_PRI, 32'h0);
      apb(0, REG_ERR_RED, 32'h0);
      apb(0, REG_ERR_PRI, 32'h0);
      chk(rd, 32'h1 << tops[i]);
    end
    do_reset();
    apb(0, REG_ERR_PRI, 32'h0);
    chk(rd, 32'h0200);
    close_out();
  end
endmodule
